/* rtl/srx_defines.svh */
`ifndef SRX_DEFINES_SVH
`define SRX_DEFINES_SVH

// Register byte addresses
`define SRX_ADDR_CTRL     8'h00
`define SRX_ADDR_STATUS   8'h04
`define SRX_ADDR_WORD     8'h08

// Control register fields
`define SRX_CTRL_MODE_LSB 0
`define SRX_CTRL_BYP_LSB  2
`define SRX_CTRL_FACT_LSB 4
`define SRX_CTRL_ROLL_LSB 8
`define SRX_CTRL_EDGE_BIT 12
`define SRX_CTRL_RESET    32'h0000_0AA0

// Status register fields
`define SRX_STAT_LOCK_BIT 0
`define SRX_STAT_LVAL_BIT 1
`define SRX_STAT_SEL_LSB  4
`define SRX_STAT_SLIP_LSB 8

// Datapath sizes and counts
`define SRX_PHASES        3'd7
`define SRX_HALF_PHASE    3'd4
`define SRX_SYNC_LAST     3'd5
`define SRX_SYNC_DEPTH    3'd6
`define SRX_SYNC_PRIME    3'd3
`define SRX_LOCK_TRANS    16
`define SRX_ROLL_MAX      4'hB
`define SRX_FACT_MAX      4'hA

`endif

/* rtl/srx_deser.sv */
`timescale 1ns/10ps
`include "srx_defines.svh"
module srx_deser (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // Lane
  srx_lane_if.deser lane
);
  srx_pkg::srx_deser_state_type s;
  srx_pkg::srx_deser_state_type next_s;
  logic       tap;
  logic       slip_edge;
  logic [9:0] w;

  // Each slip below the rollover count adds one bit-time of delay ahead of the shifter
  assign tap = (s.slip_cnt == 4'h0) ? lane.bit_in
                                     : s.dl[s.slip_cnt - 4'h1];
  assign slip_edge = lane.slip && !s.slip_q;

  always_comb begin
    next_s = s;
    next_s.word_stb = 1'b0;
    w = {s.sr[8:0], tap};
    if (lane.bit_stb) begin
      next_s.dl = {s.dl[9:0], lane.bit_in};
      next_s.sr = w;
      if (s.bitcnt >= lane.factor - 4'h1) begin
        next_s.bitcnt = 4'h0;
        for (int i = 0; i < 10; i++)
          if (i >= int'(lane.factor))
            w[i] = 1'b0;
        next_s.word = w;
        next_s.word_stb = 1'b1;
        // Slip sampled once per word, i.e. on the parallel clock
        next_s.slip_q = lane.slip;
        next_s.wrap = slip_edge && (s.slip_cnt >= lane.roll);
        if (slip_edge)
          next_s.slip_cnt = (s.slip_cnt >= lane.roll) ? 4'h0
                          : s.slip_cnt + 4'h1;
      end else begin
        next_s.bitcnt = s.bitcnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign lane.bitcnt   = s.bitcnt;
  assign lane.slip_cnt = s.slip_cnt;
  assign lane.word     = s.word;
  assign lane.word_stb = s.word_stb;
  assign lane.wrap     = s.wrap;

  a_slip_one: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (next_s.word_stb && slip_edge && s.slip_cnt < lane.roll)
    |=> s.slip_cnt == $past(s.slip_cnt) + 4'h1)
    else $error("slip did not add one bit");
  a_wrap_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(s.wrap) |-> s.slip_cnt == 4'h0)
    else $error("wrap without return to zero");
  // Wrap must drop at the next word boundary unless a new slip wraps again
  a_wrap_short: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (s.wrap && next_s.word_stb && !slip_edge) |=> !s.wrap)
    else $error("wrap flag held too long");
endmodule

/* rtl/srx_lane_if.sv */
`timescale 1ns/10ps
interface srx_lane_if;
  logic       wr_stb;
  logic       wr_bit;
  logic       rd_stb;
  logic       flush;
  logic       rd_bit;
  logic       bit_stb;
  logic       bit_in;
  logic       slip;
  logic [3:0] factor;
  logic [3:0] roll;
  logic [3:0] bitcnt;
  logic [3:0] slip_cnt;
  logic [9:0] word;
  logic       word_stb;
  logic       wrap;

  modport fifo (input wr_stb, wr_bit, rd_stb, flush, output rd_bit);
  modport deser (input bit_stb, bit_in, slip, factor, roll,
                 output bitcnt, slip_cnt, word, word_stb, wrap);
  modport ctl (output wr_stb, wr_bit, rd_stb, flush, bit_stb, bit_in,
               slip, factor, roll,
               input rd_bit, bitcnt, slip_cnt, word, word_stb, wrap);
endinterface

/* rtl/srx_pkg.sv */
package srx_pkg;

  typedef enum logic [1:0] {
    SRX_MODE_FIXED   = 2'b00,
    SRX_MODE_ALIGNED = 2'b01,
    SRX_MODE_TRACK   = 2'b10
  } srx_mode_type;

  typedef enum logic [1:0] {
    SRX_BYP_NONE = 2'b00,
    SRX_BYP_SDR  = 2'b01,
    SRX_BYP_DDR  = 2'b10
  } srx_bypass_type;

  typedef struct packed {
    logic [5:0] mem;
    logic [2:0] wp;
    logic [2:0] rp;
    logic [2:0] cnt;
    logic       primed;
    logic       rd_bit;
  } srx_sync_state_type;

  typedef struct packed {
    logic [10:0] dl;
    logic [9:0]  sr;
    logic [3:0]  bitcnt;
    logic [3:0]  slip_cnt;
    logic        slip_q;
    logic        wrap;
    logic [9:0]  word;
    logic        word_stb;
  } srx_deser_state_type;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [2:0]  bphase;
    logic        pin1;
    logic        pin2;
    logic        pin3;
    logic        cap_f;
    logic [2:0]  sel;
    logic [4:0]  trans;
    logic        locked;
    logic [3:0]  pcnt;
    logic        a_wr;
    logic [7:0]  a_addr;
    logic [9:0]  word;
    logic        wvalid;
    logic        wrap;
    logic        lock_o;
    logic        lvalid;
    logic        pclk;
    logic        fclk;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
  } srx_top_state_type;

endpackage

/* rtl/srx_rx_top.sv */
`timescale 1ns/10ps
`include "srx_defines.svh"
module srx_rx_top #(
  parameter int LOCK_TRANS = `SRX_LOCK_TRANS
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Serial pin
  input  wire logic        ser_data_i,
  // Fabric controls
  input  wire logic        slip_req_i,
  input  wire logic        sync_flush_i,
  input  wire logic        phase_freeze_i,
  input  wire logic        aligner_reset_i,
  // Fabric outputs
  output logic      [9:0]  word_o,
  output logic             word_valid_o,
  output logic             slip_wrap_o,
  output logic             locked_o,
  output logic             lock_valid_o,
  output logic             par_clk_o,
  output logic             fwd_clk_o
);
  srx_pkg::srx_top_state_type s;
  srx_pkg::srx_top_state_type next_s;
  srx_pkg::srx_mode_type      mode;
  srx_pkg::srx_bypass_type    byp;
  srx_lane_if                 lane ();

  logic [1:0]  rst_q;
  logic        rst_n;
  logic [3:0]  factor;
  logic [3:0]  roll;
  logic        ser_stb;
  logic        fall_stb;
  logic        sel_stb;
  logic        trans_seen;
  logic [2:0]  target;
  logic        first_lock;
  logic        addr_ok;
  logic        wr_ctrl;
  logic [31:0] ctrl_now;
  logic [31:0] status;

  // Reset release through two flops
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      rst_q <= 2'b00;
    else
      rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  // Unsupported word sizes fall back to ten bits
  function automatic logic [3:0] legal_factor(input logic [3:0] f);
    case (f)
      4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'hA: legal_factor = f;
      default: legal_factor = `SRX_FACT_MAX;
    endcase
  endfunction

  assign mode   = srx_pkg::srx_mode_type'(s.ctrl[`SRX_CTRL_MODE_LSB +: 2]);
  assign byp    = srx_pkg::srx_bypass_type'(s.ctrl[`SRX_CTRL_BYP_LSB +: 2]);
  assign factor = legal_factor(s.ctrl[`SRX_CTRL_FACT_LSB +: 4]);
  // Rollover clamped to 1..11 bit-times
  assign roll = (s.ctrl[`SRX_CTRL_ROLL_LSB +: 4] == 4'h0) ? 4'h1 :
                (s.ctrl[`SRX_CTRL_ROLL_LSB +: 4] > `SRX_ROLL_MAX) ?
                `SRX_ROLL_MAX : s.ctrl[`SRX_CTRL_ROLL_LSB +: 4];

  // Serial clock edges and the eight sampling phases per bit
  assign ser_stb  = (s.bphase == 3'h0);
  assign fall_stb = (s.bphase == `SRX_HALF_PHASE);
  assign sel_stb  = (s.bphase == s.sel);

  // Aligner: sample half a bit away from the last transition
  assign trans_seen = (s.pin2 != s.pin3);
  assign target     = s.bphase + `SRX_HALF_PHASE;
  assign first_lock = trans_seen && !s.locked &&
                      (s.trans == 5'(LOCK_TRANS - 1));

  // Datapath routing per mode
  always_comb begin
    lane.wr_stb = 1'b0;
    lane.wr_bit = s.pin2;
    lane.rd_stb = 1'b0;
    lane.bit_stb = 1'b0;
    lane.bit_in = s.pin2;
    lane.slip = 1'b0;
    if (byp == srx_pkg::SRX_BYP_NONE) begin
      lane.slip = slip_req_i;
      unique case (mode)
        srx_pkg::SRX_MODE_ALIGNED: begin
          lane.wr_stb  = sel_stb;
          lane.rd_stb  = ser_stb;
          lane.bit_stb = ser_stb;
          lane.bit_in  = lane.rd_bit;
        end
        srx_pkg::SRX_MODE_TRACK: begin
          lane.bit_stb = sel_stb;
          lane.bit_in  = s.pin2;
        end
        default: begin
          lane.bit_stb = ser_stb;
          lane.bit_in  = s.ctrl[`SRX_CTRL_EDGE_BIT] ? s.cap_f
                                                   : s.pin2;
        end
      endcase
    end
  end
  assign lane.flush  = sync_flush_i || first_lock ||
                       mode != srx_pkg::SRX_MODE_ALIGNED;
  assign lane.factor = factor;
  assign lane.roll   = roll;

  srx_sync u_sync (
    .clk_i   (core_clk_i),
    .rst_b_i (rst_n),
    .lane    (lane.fifo)
  );

  srx_deser u_deser (
    .clk_i   (core_clk_i),
    .rst_b_i (rst_n),
    .lane    (lane.deser)
  );

  // Bus decode
  assign addr_ok = hsel_i && htrans_i[1] && hready_i;
  assign wr_ctrl = s.a_wr && (s.a_addr == `SRX_ADDR_CTRL);
  // A read right after a control write sees the new value
  assign ctrl_now = wr_ctrl ? hwdata_i : s.ctrl;

  always_comb begin
    status = 32'h0000_0000;
    status[`SRX_STAT_LOCK_BIT] = s.locked;
    status[`SRX_STAT_LVAL_BIT] = s.lvalid;
    status[`SRX_STAT_SEL_LSB +: 3] = s.sel;
    status[`SRX_STAT_SLIP_LSB +: 4] = lane.slip_cnt;
  end

  always_comb begin
    next_s = s;
    next_s.hready = 1'b1;
    next_s.hresp  = 1'b0;
    next_s.wvalid = 1'b0;

    // Pin synchroniser; first flop only feeds the second
    next_s.pin1 = ser_data_i;
    next_s.pin2 = s.pin1;
    next_s.pin3 = s.pin2;
    next_s.bphase = (s.bphase == `SRX_PHASES) ? 3'h0 : s.bphase + 3'h1;
    if (fall_stb)
      next_s.cap_f = s.pin2;

    // Phase aligner, idle whenever the deserializer is bypassed
    if (aligner_reset_i || mode == srx_pkg::SRX_MODE_FIXED ||
        byp != srx_pkg::SRX_BYP_NONE) begin
      next_s.trans  = 5'h00;
      next_s.locked = 1'b0;
    end else if (trans_seen) begin
      if (!phase_freeze_i)
        next_s.sel = target;
      if (!s.locked)
        next_s.trans = s.trans + 5'h01;
      if (first_lock)
        next_s.locked = 1'b1;
    end

    // PLL parallel clock runs in every mode
    if (ser_stb) begin
      next_s.pcnt = (s.pcnt >= factor - 4'h1) ? 4'h0 : s.pcnt + 4'h1;
      next_s.pclk = next_s.pcnt < (factor >> 1);
    end
    next_s.fclk = (mode == srx_pkg::SRX_MODE_TRACK) &&
                  (lane.bitcnt < (factor >> 1));

    // Words to fabric
    if (byp != srx_pkg::SRX_BYP_NONE) begin
      if (ser_stb) begin
        next_s.wvalid = 1'b1;
        next_s.word = (byp == srx_pkg::SRX_BYP_DDR) ?
                      {8'h00, s.pin2, s.cap_f} : {9'h000, s.pin2};
      end
      next_s.wrap = 1'b0;
    end else begin
      if (lane.word_stb) begin
        next_s.wvalid = 1'b1;
        next_s.word   = lane.word;
      end
      next_s.wrap = lane.wrap;
    end
    next_s.lock_o = s.locked;
    next_s.lvalid = s.locked && mode != srx_pkg::SRX_MODE_TRACK;

    // AHB-Lite: zero wait states, reads registered in address phase
    next_s.a_wr = addr_ok && hwrite_i;
    next_s.a_addr = haddr_i[7:0];
    if (wr_ctrl)
      next_s.ctrl = hwdata_i;
    if (addr_ok && !hwrite_i) begin
      if (haddr_i[31:8] != 24'h000000)
        next_s.hrdata = 32'h0000_0000;
      else
        case (haddr_i[7:0])
          `SRX_ADDR_CTRL:   next_s.hrdata = ctrl_now;
          `SRX_ADDR_STATUS: next_s.hrdata = status;
          `SRX_ADDR_WORD:   next_s.hrdata = {22'h000000, s.word};
          default:          next_s.hrdata = 32'h0000_0000;
        endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s        <= '0;
      s.ctrl   <= `SRX_CTRL_RESET;
      s.hready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata_o     = s.hrdata;
  assign hreadyout_o  = s.hready;
  assign hresp_o      = s.hresp;
  assign word_o       = s.word;
  assign word_valid_o = s.wvalid;
  assign slip_wrap_o  = s.wrap;
  assign locked_o     = s.lock_o;
  assign lock_valid_o = s.lvalid;
  assign par_clk_o    = s.pclk;
  assign fwd_clk_o    = s.fclk;

  a_lock_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (s.locked && !aligner_reset_i && mode != srx_pkg::SRX_MODE_FIXED &&
     byp == srx_pkg::SRX_BYP_NONE) |=> s.locked)
    else $error("lock dropped without aligner reset");
  a_freeze_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    phase_freeze_i |=> $stable(s.sel))
    else $error("phase moved while frozen");
  a_lock_flush: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (!s.locked ##1 s.locked) |-> $past(lane.flush))
    else $error("first lock did not flush sync");
  a_sync_bypass: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    mode != srx_pkg::SRX_MODE_ALIGNED |-> !lane.wr_stb && lane.flush)
    else $error("sync used outside aligned mode");
  a_track_invalid: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    mode == srx_pkg::SRX_MODE_TRACK |=> !lock_valid_o)
    else $error("lock shown valid in tracking");
  a_word_delay: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    lane.word_stb && byp == srx_pkg::SRX_BYP_NONE |=>
    word_valid_o && word_o == $past(lane.word))
    else $error("word not passed to fabric");
endmodule

/* rtl/srx_sync.sv */
`timescale 1ns/10ps
`include "srx_defines.svh"
module srx_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // Lane
  srx_lane_if.fifo  lane
);
  srx_pkg::srx_sync_state_type s;
  srx_pkg::srx_sync_state_type next_s;
  logic do_wr;
  logic do_rd;

  // Reads wait for half fill so only phase offset is absorbed
  assign do_rd = lane.rd_stb && s.primed && (s.cnt != 3'h0);
  assign do_wr = lane.wr_stb && (s.cnt < `SRX_SYNC_DEPTH);

  always_comb begin
    next_s = s;
    if (do_rd) begin
      next_s.rd_bit = s.mem[s.rp];
      next_s.rp = (s.rp == `SRX_SYNC_LAST) ? 3'h0 : s.rp + 3'h1;
    end
    if (do_wr) begin
      next_s.mem[s.wp] = lane.wr_bit;
      next_s.wp = (s.wp == `SRX_SYNC_LAST) ? 3'h0 : s.wp + 3'h1;
    end
    next_s.cnt = s.cnt + {2'h0, do_wr} - {2'h0, do_rd};
    if (next_s.cnt >= `SRX_SYNC_PRIME)
      next_s.primed = 1'b1;
    if (lane.flush)
      next_s = '0;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign lane.rd_bit = s.rd_bit;

  a_sync_depth: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s.cnt <= `SRX_SYNC_DEPTH) else $error("sync fill above six");
  a_flush_empty: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    lane.flush |=> (s.cnt == 3'h0 && !s.primed))
    else $error("flush left data in sync");
endmodule

/* testbench/srx_far_end.sv */
`timescale 1ns/10ps
module srx_far_end (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // Pattern set-up
  input  wire logic [9:0] pat_i,
  input  wire logic [3:0] factor_i,
  // Serial line
  output logic            ser_o
);
  logic [2:0] ph;
  logic [3:0] idx;

  // Most significant used bit leaves first, one bit per eight cycles;
  // edges fall on phase 3 so the receiver sees a real skew
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ph <= 3'h0;
      idx <= 4'h0;
      ser_o <= 1'b0;
    end else begin
      ph <= ph + 3'h1;
      if (ph == 3'h3) begin
        ser_o <= pat_i[idx];
        idx <= (idx == 4'h0 || idx >= factor_i) ? factor_i - 4'h1
                                                 : idx - 4'h1;
      end
    end
  end
endmodule

/* testbench/srx_rx_top_bench.sv */
`timescale 1ns/10ps
`include "srx_defines.svh"
module srx_rx_top_bench;
  logic        clk;
  logic        rst_b;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        ser;
  logic        slip;
  logic        flush;
  logic        freeze;
  logic        areset;
  logic [9:0]  word;
  logic        wvalid;
  logic        wrap;
  logic        locked;
  logic        lvalid;
  logic        pclk;
  logic        fclk;
  logic [9:0]  pat;
  logic [3:0]  fact;
  logic        wseen;
  logic [31:0] rd;
  logic [31:0] s1;
  logic [9:0]  w;
  logic [9:0]  w0;
  int          miscompares;
  int          n_tests;
  int          tf;
  int          tp;
  logic [7:0]  tbl [7] = '{8'h33, 8'h44, 8'h66, 8'h77, 8'h88, 8'hAA, 8'hAB};

  srx_rx_top #(.LOCK_TRANS(4)) srx_rx_top_inst (
    .core_clk_i(clk), .rst_b_i(rst_b), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .ser_data_i(ser),
    .slip_req_i(slip), .sync_flush_i(flush), .phase_freeze_i(freeze),
    .aligner_reset_i(areset), .word_o(word), .word_valid_o(wvalid),
    .slip_wrap_o(wrap), .locked_o(locked), .lock_valid_o(lvalid),
    .par_clk_o(pclk), .fwd_clk_o(fclk));

  srx_far_end srx_far_end_inst (
    .clk_i(clk), .rst_b_i(rst_b), .pat_i(pat), .factor_i(fact),
    .ser_o(ser));

  always #10 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("compares=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic expire;
    miscompares++;
    test_done;
  endtask

  task automatic hwait;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) expire;
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hwait;
    htrans <= 2'b00;
    hwdata <= wd;
    hwait;
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Wrap level is gathered on every polled cycle so a short pulse is kept
  task automatic wait_word(output logic [9:0] v);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      wseen = wseen | wrap;
    end while (wvalid !== 1'b1 && n < 400);
    if (wvalid !== 1'b1) expire;
    v = word;
  endtask

  function automatic logic [9:0] rotr(input logic [9:0] v, input int f,
                                      input int k);
    logic [9:0] r;
    r = v;
    for (int i = 0; i < k; i++) begin
      r = (r >> 1) | (10'(r[0]) << (f - 1));
    end
    return r;
  endfunction

  function automatic logic [9:0] as_rot(input logic [9:0] v, input int f);
    logic [9:0] m;
    m = 10'h3FF;
    for (int k = 0; k < f; k++) begin
      if (rotr(pat & ((10'h1 << f) - 10'h1), f, k) === v) m = v;
    end
    return m;
  endfunction

  // Bypass strobes every bit, not every word, so a fixed span stands in for two words
  task automatic gap(input logic byp);
    if (byp) repeat (160) @(posedge clk);
    else repeat (2) wait_word(w);
  endtask

  task automatic slip_once(input logic byp);
    @(posedge clk);
    slip <= 1'b1;
    gap(byp);
    @(posedge clk);
    slip <= 1'b0;
    gap(byp);
  endtask

  task automatic cfg(input logic [1:0] md, input logic [1:0] by,
                     input int f, input int r, input logic e);
    logic [31:0] v;
    v = {19'h0, e, 4'(r), 4'(f), by, md};
    ahb(1'b1, `SRX_ADDR_CTRL, v, rd);
    ahb(1'b0, `SRX_ADDR_CTRL, 32'h0, rd);
    chk(rd, v);
    fact <= 4'(f);
    if (by == 2'b00) repeat (3) wait_word(w);
    else repeat (80) @(posedge clk);
  endtask

  task automatic run_case(input logic [1:0] md, input int f, input int r,
                          input logic e);
    logic [31:0] s;
    int c;
    cfg(md, 2'b00, f, r, e);
    wait_word(w0);
    chk({22'h0, w0}, {22'h0, as_rot(w0, f)});
    ahb(1'b0, `SRX_ADDR_WORD, 32'h0, rd);
    chk(rd, {22'h0, w0});
    ahb(1'b0, `SRX_ADDR_STATUS, 32'h0, s);
    c = s[11:8];
    repeat (r + 1) begin
      wseen = 1'b0;
      slip_once(1'b0);
      wait_word(w);
      ahb(1'b0, `SRX_ADDR_STATUS, 32'h0, s);
      chk({31'h0, wseen}, {31'h0, c == r});
      w0 = (c == r) ? rotr(w0, f, f - (r % f)) : rotr(w0, f, 1);
      c = (c == r) ? 0 : c + 1;
      chk({22'h0, w}, {22'h0, w0});
      chk(s & 32'hF00, 32'(c) << 8);
    end
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    slip = 1'b0;
    flush = 1'b0;
    freeze = 1'b0;
    areset = 1'b0;
    pat = 10'h2E3;
    fact = 4'hA;
    wseen = 1'b0;
    miscompares = 0;
    n_tests = 0;
    tf = 0;
    tp = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    ahb(1'b0, `SRX_ADDR_CTRL, 32'h0, rd);
    chk(rd, `SRX_CTRL_RESET);
    ahb(1'b0, 8'h0C, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b1, `SRX_ADDR_STATUS, 32'hFFFF_FFFF, rd);
    ahb(1'b0, `SRX_ADDR_STATUS, 32'h0, rd);
    chk(rd & 32'h0000_0F03, 32'h0);
    run_case(2'b00, 4, 4, 1'b1);
    chk({30'h0, locked, fclk}, 32'h0);
    foreach (tbl[i]) run_case(2'b01, tbl[i][7:4], tbl[i][3:0], 1'b0);
    ahb(1'b0, `SRX_ADDR_STATUS, 32'h0, s1);
    chk(s1 & 32'h3, 32'h3);
    freeze <= 1'b1;
    repeat (4) wait_word(w);
    ahb(1'b0, `SRX_ADDR_STATUS, 32'h0, rd);
    chk(rd & 32'h73, s1 & 32'h73);
    freeze <= 1'b0;
    flush <= 1'b1;
    @(posedge clk);
    flush <= 1'b0;
    repeat (4) wait_word(w);
    chk({22'h0, w}, {22'h0, as_rot(w, 10)});
    @(posedge clk);
    areset <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({31'h0, locked}, 32'h0);
    @(posedge clk);
    areset <= 1'b0;
    repeat (3) wait_word(w);
    chk({31'h0, locked}, 32'h1);
    run_case(2'b10, 8, 8, 1'b0);
    repeat (300) begin
      @(posedge clk);
      #1;
      if (fclk !== fclk_prev()) tf++;
      if (pclk !== pclk_prev()) tp++;
    end
    chk({30'h0, tf > 3, tp > 3}, 32'h3);
    chk({31'h0, lvalid}, 32'h0);
    for (int b = 1; b < 3; b++) begin
      cfg(2'b00, 2'(b), 10, 10, 1'b0);
      ahb(1'b0, `SRX_ADDR_STATUS, 32'h0, s1);
      slip_once(1'b1);
      ahb(1'b0, `SRX_ADDR_STATUS, 32'h0, rd);
      chk(rd & 32'hF00, s1 & 32'hF00);
      chk({22'h0, word} & (32'h3FF << b), 32'h0);
    end
    test_done;
  end

  logic fq;
  logic pq;
  always @(posedge clk) begin
    fq <= fclk;
    pq <= pclk;
  end

  function automatic logic fclk_prev();
    return fq;
  endfunction

  function automatic logic pclk_prev();
    return pq;
  endfunction
endmodule
